/* core/mrr_map.svh */
// Constants of the move, return and rotate execution block.
// Included by the package user files; holds definitions only.
`ifndef MRR_MAP_SVH
`define MRR_MAP_SVH

// Software register offsets (byte addresses)
`define MRR_OFF_CTRL 8'h00
`define MRR_OFF_FLAGS 8'h04
`define MRR_OFF_WORK 8'h08
`define MRR_OFF_BANK 8'h0c
`define MRR_OFF_PC 8'h10

// Control register fields
`define MRR_CTRL_EXT 0
`define MRR_CTRL_HI_EN 1
`define MRR_CTRL_LO_EN 2

// Status flag positions
`define MRR_FLAG_C 0
`define MRR_FLAG_Z 2
`define MRR_FLAG_N 4

// Reset values
`define MRR_RST_CTRL 3'h0
`define MRR_RST_BYTE 8'h00

// Opcode patterns and masks
`define MRR_OP_LITW 16'h0e00
`define MRR_MK_LITW 16'hff00
`define MRR_OP_WSTORE 16'h6e00
`define MRR_MK_WSTORE 16'hfe00
`define MRR_OP_FMOVE 16'hc000
`define MRR_MK_FMOVE 16'hf000
`define MRR_OP_IEXIT 16'h0010
`define MRR_OP_SEXIT 16'h0012
`define MRR_MK_EXIT 16'hfffe
`define MRR_OP_TEXIT 16'h0c00
`define MRR_MK_TEXIT 16'hff00
`define MRR_OP_ROT 16'h3400
`define MRR_MK_ROT 16'hfc00

// Instruction word fields
`define MRR_BIT_A 8
`define MRR_BIT_D 9
`define MRR_BIT_S 0

// Access bank split and literal offset limit
`define MRR_ACC_SPLIT 8'h60
`define MRR_IDX_MAX 8'h5f
`define MRR_ACC_HIGH 4'hf

// Quarter phases: Q1..Q4 as counts 0..3
`define MRR_Q1 2'h0
`define MRR_Q2 2'h1
`define MRR_Q3 2'h2
`define MRR_Q4 2'h3

// Program counter step per instruction word
`define MRR_PC_STEP 2
`endif

/* core/mrr_pkg.sv */
// Types of the move, return and rotate execution block.
// Uses no macros; does not include mrr_map.svh.
package mrr_pkg;
  typedef enum logic [2:0] {
    MRR_ST_IDLE,
    MRR_ST_EXEC,
    MRR_ST_WORD2,
    MRR_ST_MOVE2,
    MRR_ST_NOP2
  } mrr_state_t;

  typedef enum logic [2:0] {
    MRR_OPC_NONE,
    MRR_OPC_LITW,
    MRR_OPC_WSTORE,
    MRR_OPC_FMOVE,
    MRR_OPC_IEXIT,
    MRR_OPC_SEXIT,
    MRR_OPC_TEXIT,
    MRR_OPC_ROT
  } mrr_opc_t;
endpackage

/* core/mrr_addr_gen.sv */
// File address former for single-word file-register instructions.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
`include "mrr_map.svh"

module mrr_addr_gen import mrr_pkg::*; (
  // Instruction fields
  input wire logic [7:0] file_sel,
  input wire logic bank_access,
  // Context
  input wire logic [7:0] bank_sel,
  input wire logic ext_enable,
  input wire logic [11:0] index_base,
  // Result
  output logic [11:0] file_addr
);
  // Bank bit picks access bank or selected bank
  always_comb begin
    if (bank_access) begin
      file_addr = {bank_sel[3:0], file_sel};
    end else if (ext_enable && file_sel <= `MRR_IDX_MAX) begin
      // Wraps within the data space, as the index register does
      file_addr = index_base + {4'h0, file_sel};
    end else if (file_sel < `MRR_ACC_SPLIT) begin
      file_addr = {4'h0, file_sel};
    end else begin
      file_addr = {`MRR_ACC_HIGH, file_sel};
    end
  end
endmodule
`default_nettype wire

/* core/mrr_exec.sv */
// Executes literal and register moves, returns and rotate-through-carry.
// Assumes fetch, data memory and return stack share clk_sys; memory read data
// arrive the cycle after the read strobe.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "mrr_map.svh"

module mrr_exec import mrr_pkg::*; #(
  parameter int PC_W = 21
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Instruction fetch
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  output logic [PC_W-1:0] pc_value,
  // Data memory
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic [11:0] index_base,
  // Return stack
  input wire logic [PC_W-1:0] stack_top,
  output logic stack_pop,
  // Shadow copies
  input wire logic [7:0] working_shadow,
  input wire logic [7:0] flags_shadow,
  input wire logic [7:0] bank_select_shadow,
  // Core state
  output logic [7:0] working_reg,
  output logic [7:0] flags_reg,
  output logic [7:0] bank_select_reg,
  output logic high_priority_global_irq_enable,
  output logic low_priority_global_irq_enable,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  // Refuse PC widths that the read mux and stack port cannot serve
  if (PC_W < 9 || PC_W > 32) begin : g_pc_w_bad
    $error("PC_W must lie between 9 and 32");
  end

  // Classify one instruction word
  function automatic mrr_opc_t op_class(input logic [15:0] iw);
    mrr_opc_t c;
    c = MRR_OPC_NONE;
    if ((iw & `MRR_MK_LITW) == `MRR_OP_LITW) c = MRR_OPC_LITW;
    else if ((iw & `MRR_MK_WSTORE) == `MRR_OP_WSTORE) c = MRR_OPC_WSTORE;
    else if ((iw & `MRR_MK_FMOVE) == `MRR_OP_FMOVE) c = MRR_OPC_FMOVE;
    else if ((iw & `MRR_MK_EXIT) == `MRR_OP_IEXIT) c = MRR_OPC_IEXIT;
    else if ((iw & `MRR_MK_EXIT) == `MRR_OP_SEXIT) c = MRR_OPC_SEXIT;
    else if ((iw & `MRR_MK_TEXIT) == `MRR_OP_TEXIT) c = MRR_OPC_TEXIT;
    else if ((iw & `MRR_MK_ROT) == `MRR_OP_ROT) c = MRR_OPC_ROT;
    return c;
  endfunction

  // Any of the three returns
  function automatic logic is_exit(input mrr_opc_t c);
    return c == MRR_OPC_IEXIT || c == MRR_OPC_SEXIT || c == MRR_OPC_TEXIT;
  endfunction

  mrr_state_t st_q, st_d;
  logic [1:0] qph_q, qph_d;
  logic [15:0] ir_q, ir_d;
  logic [15:0] ir2_q, ir2_d;
  logic [7:0] data_q, data_d;
  logic [7:0] w_q, w_d;
  logic [7:0] flg_q, flg_d;
  logic [7:0] bsel_q, bsel_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic en_hi_q, en_hi_d;
  logic en_lo_q, en_lo_d;
  logic ext_q, ext_d;
  logic [11:0] madr_q, madr_d;
  logic [7:0] mwd_q, mwd_d;
  logic mrd_q, mrd_d;
  logic mwr_q, mwr_d;
  logic pop_q, pop_d;
  logic [31:0] rdat_q, rdat_d;
  logic [11:0] faddr;
  mrr_opc_t opc;
  logic [7:0] rot_res;
  logic rot_c;
  logic take;

  mrr_addr_gen u_addr (
    .file_sel(ir_q[7:0]),
    .bank_access(ir_q[`MRR_BIT_A]),
    .bank_sel(bsel_q),
    .ext_enable(ext_q),
    .index_base(index_base),
    .file_addr(faddr)
  );

  assign opc = op_class(ir_q);
  // Returns hold off fetch until their idle second cycle
  assign instr_ready = (qph_q == `MRR_Q4) && (st_q != MRR_ST_WORD2)
    && !(st_q == MRR_ST_EXEC && is_exit(opc));
  assign take = instr_ready && instr_valid;

  // Rotate result straight from the memory read data
  assign rot_res = {mem_rdata[6:0], flg_q[`MRR_FLAG_C]};
  assign rot_c = mem_rdata[7];

  // Next state of sequencer, core registers and memory port
  always_comb begin
    st_d = st_q;
    qph_d = qph_q + 2'h1;
    ir_d = ir_q;
    ir2_d = ir2_q;
    data_d = data_q;
    w_d = w_q;
    flg_d = flg_q;
    bsel_d = bsel_q;
    pc_d = pc_q;
    en_hi_d = en_hi_q;
    en_lo_d = en_lo_q;
    ext_d = ext_q;
    madr_d = madr_q;
    mwd_d = mwd_q;
    mrd_d = 1'b0;
    mwr_d = 1'b0;
    pop_d = 1'b0;
    // Software writes first, so hardware updates below win a collision
    if (reg_wr) begin
      unique case (reg_addr)
        `MRR_OFF_CTRL: begin
          ext_d = reg_wdata[`MRR_CTRL_EXT];
          en_hi_d = reg_wdata[`MRR_CTRL_HI_EN];
          en_lo_d = reg_wdata[`MRR_CTRL_LO_EN];
        end
        `MRR_OFF_BANK: bsel_d = {4'h0, reg_wdata[3:0]};
        default: ;
      endcase
    end
    unique case (st_q)
      MRR_ST_EXEC: begin
        // Strobes are registered, so issue one quarter early
        if (qph_q == `MRR_Q1) begin
          if (opc == MRR_OPC_FMOVE) begin
            mrd_d = 1'b1;
            madr_d = ir_q[11:0];
          end else if (opc == MRR_OPC_ROT) begin
            mrd_d = 1'b1;
            madr_d = faddr;
          end
        end
        if (qph_q == `MRR_Q3) begin
          data_d = mem_rdata;
          if (opc == MRR_OPC_WSTORE) begin
            mwr_d = 1'b1;
            madr_d = faddr;
            mwd_d = w_q;
          end
          if (opc == MRR_OPC_ROT) begin
            flg_d[`MRR_FLAG_C] = rot_c;
            flg_d[`MRR_FLAG_N] = rot_res[7];
            flg_d[`MRR_FLAG_Z] = (rot_res == 8'h00);
            if (ir_q[`MRR_BIT_D]) begin
              mwr_d = 1'b1;
              mwd_d = rot_res;
            end else begin
              w_d = rot_res;
            end
          end
        end
        if (qph_q == `MRR_Q4) begin
          unique case (opc)
            MRR_OPC_LITW: w_d = ir_q[7:0];
            MRR_OPC_TEXIT: begin
              w_d = ir_q[7:0];
              pc_d = stack_top;
              pop_d = 1'b1;
            end
            MRR_OPC_IEXIT, MRR_OPC_SEXIT: begin
              pc_d = stack_top;
              pop_d = 1'b1;
              if (ir_q[`MRR_BIT_S]) begin
                w_d = working_shadow;
                flg_d = flags_shadow;
                bsel_d = bank_select_shadow;
              end
              // High enable still set means a low level is returning
              if (opc == MRR_OPC_IEXIT) begin
                if (en_hi_q) en_lo_d = 1'b1;
                else en_hi_d = 1'b1;
              end
            end
            default: ;
          endcase
        end
      end
      MRR_ST_MOVE2: begin
        // No dummy read in this cycle; only the late write
        if (qph_q == `MRR_Q3) begin
          mwr_d = 1'b1;
          madr_d = ir2_q[11:0];
          mwd_d = data_q;
        end
      end
      default: ;
    endcase
    // Cycle boundary
    if (qph_q == `MRR_Q4) begin
      if (st_q == MRR_ST_EXEC && opc == MRR_OPC_FMOVE || st_q == MRR_ST_WORD2) begin
        if (instr_valid) begin
          ir2_d = instr_word;
          pc_d = pc_q + PC_W'(`MRR_PC_STEP);
          st_d = MRR_ST_MOVE2;
        end else begin
          st_d = MRR_ST_WORD2;
        end
      end else if (st_q == MRR_ST_EXEC && is_exit(opc)) begin
        st_d = MRR_ST_NOP2;
      end else if (take) begin
        ir_d = instr_word;
        pc_d = pc_q + PC_W'(`MRR_PC_STEP);
        st_d = MRR_ST_EXEC;
      end else begin
        st_d = MRR_ST_IDLE;
      end
    end
    // Read data for the cycle after the read strobe
    rdat_d = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `MRR_OFF_CTRL: rdat_d = {29'h0, en_lo_q, en_hi_q, ext_q};
        `MRR_OFF_FLAGS: rdat_d = {24'h0, flg_q};
        `MRR_OFF_WORK: rdat_d = {24'h0, w_q};
        `MRR_OFF_BANK: rdat_d = {24'h0, bsel_q};
        `MRR_OFF_PC: rdat_d = 32'(pc_q);
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= MRR_ST_IDLE;
      qph_q <= `MRR_Q1;
      ir_q <= 16'h0000;
      ir2_q <= 16'h0000;
      data_q <= `MRR_RST_BYTE;
      w_q <= `MRR_RST_BYTE;
      flg_q <= `MRR_RST_BYTE;
      bsel_q <= `MRR_RST_BYTE;
      pc_q <= '0;
      en_hi_q <= 1'b0;
      en_lo_q <= 1'b0;
      ext_q <= 1'b0;
      madr_q <= 12'h000;
      mwd_q <= `MRR_RST_BYTE;
      mrd_q <= 1'b0;
      mwr_q <= 1'b0;
      pop_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      qph_q <= qph_d;
      ir_q <= ir_d;
      ir2_q <= ir2_d;
      data_q <= data_d;
      w_q <= w_d;
      flg_q <= flg_d;
      bsel_q <= bsel_d;
      pc_q <= pc_d;
      en_hi_q <= en_hi_d;
      en_lo_q <= en_lo_d;
      ext_q <= ext_d;
      madr_q <= madr_d;
      mwd_q <= mwd_d;
      mrd_q <= mrd_d;
      mwr_q <= mwr_d;
      pop_q <= pop_d;
      rdat_q <= rdat_d;
    end
  end

  // Outputs straight from flops
  assign pc_value = pc_q;
  assign mem_addr = madr_q;
  assign mem_rd = mrd_q;
  assign mem_wr = mwr_q;
  assign mem_wdata = mwd_q;
  assign stack_pop = pop_q;
  assign working_reg = w_q;
  assign flags_reg = flg_q;
  assign bank_select_reg = bsel_q;
  assign high_priority_global_irq_enable = en_hi_q;
  assign low_priority_global_irq_enable = en_lo_q;
  assign reg_rdata = rdat_q;
endmodule
`default_nettype wire

/* dv/mrr_exec_asserts.sv */
// Checker for the move, return and rotate block.
// Bound to mrr_exec; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module mrr_exec_asserts import mrr_pkg::*; #(
  parameter int PC_W = 21
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Watched ports
  input wire logic instr_ready,
  input wire logic [PC_W-1:0] pc_value,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [PC_W-1:0] stack_top,
  input wire logic stack_pop,
  input wire logic reg_wr,
  input wire logic high_priority_global_irq_enable,
  input wire logic low_priority_global_irq_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Writes land in Q4, where the next word is offered
  wr_in_q4_a: assert property (mem_wr |-> instr_ready)
    else $error("write outside Q4");
  // At most one read per instruction cycle: no read in the three clocks after a read
  rd_gap_a: assert property (mem_rd |=> (!mem_rd)[*3])
    else $error("extra read");
  // Popped value is already in the PC
  pop_pc_a: assert property (stack_pop |-> pc_value == $past(stack_top))
    else $error("pc not from stack");
  // Second cycle of a return is idle
  pop_idle_a: assert property (stack_pop |-> (!instr_ready)[*3] ##1 instr_ready)
    else $error("return not two cycles");
  pop_hold_a: assert property (stack_pop |=> !stack_pop && $stable(pc_value))
    else $error("pc moved in idle cycle");
  ready_gap_a: assert property (instr_ready |=> (!instr_ready)[*3])
    else $error("word offered twice");
  // Enables rise only with a return pop or after a software write
  high_en_rise_a: assert property ($rose(high_priority_global_irq_enable) |-> stack_pop || $past(reg_wr))
    else $error("high enable without return");
  low_en_rise_a: assert property ($rose(low_priority_global_irq_enable) |-> stack_pop || $past(reg_wr))
    else $error("low enable without return");
  // Main scenarios
  cover property (stack_pop);
  cover property (mem_rd ##2 mem_wr);
  cover property (mem_wr);
endmodule
bind mrr_exec mrr_exec_asserts #(.PC_W(PC_W)) u_chk (.clk_sys, .rst_n, .instr_ready, .pc_value,
  .mem_rd, .mem_wr, .stack_top, .stack_pop, .reg_wr, .high_priority_global_irq_enable,
  .low_priority_global_irq_enable);
`default_nettype wire

/* dv/mrr_far_model.sv */
// Far side model: data memory and return stack.
// Shares clk_sys; the bench may preload mem and stk.
`timescale 1ns/1ns
`default_nettype none
module mrr_far_model import mrr_pkg::*; #(
  parameter int PC_W = 21
) (
  // Clock
  input wire logic clk_sys,
  // Data memory
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  // Return stack
  output logic [PC_W-1:0] stack_top,
  input wire logic stack_pop
);
  logic [7:0] mem [4096];
  logic [PC_W-1:0] stk [8];
  logic [7:0] rd_q = 8'h00;
  logic hit_q = 1'b0;
  int sp = 7;
  // Stale data inverted so a late sample shows
  assign mem_rdata = hit_q ? rd_q : ~rd_q;
  assign stack_top = stk[sp];
  // Stack entry i holds i * 256
  initial for (int i = 0; i < 8; i++) stk[i] = PC_W'(i) << 8;
  // Plain always: bench preloads share these arrays
  always @(posedge clk_sys) begin
    hit_q <= mem_rd;
    if (mem_rd) rd_q <= mem[mem_addr];
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    if (stack_pop) sp <= sp - 1;
  end
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the move, return and rotate block.
// Drives fetch and register port; far model holds memory and stack.
`timescale 1ns/1ns
`default_nettype none
`include "mrr_map.svh"
module testbench import mrr_pkg::*;;
  logic clk_sys = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic instr_ready, stack_pop, mem_rd, mem_wr, gh, gl;
  logic [20:0] pc_value, stack_top;
  logic [11:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, working_reg, flags_reg, bank_select_reg, reg_addr = 8'h00;
  logic [7:0] working_shadow = 8'ha1, flags_shadow = 8'h10, bank_select_shadow = 8'h05;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  int n_mismatch = 0, comparisons = 0;
  always #5 clk_sys = ~clk_sys;
  mrr_exec dut (.clk_sys, .rst_n, .instr_valid, .instr_word, .instr_ready, .pc_value, .mem_addr,
    .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .index_base(12'h200), .stack_top, .stack_pop,
    .working_shadow, .flags_shadow, .bank_select_shadow, .working_reg, .flags_reg, .bank_select_reg,
    .high_priority_global_irq_enable(gh), .low_priority_global_irq_enable(gl), .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  mrr_far_model far (.clk_sys, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .stack_top,
    .stack_pop);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a word slot
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (instr_ready !== 1'b1 && n < 40);
    chk(instr_ready, 1);
  endtask
  // One instruction; a file move holds its second word to the next Q4
  task automatic run(input logic [15:0] w1, input logic [15:0] w2, input bit two);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w1;
    wait_rdy();
    if (two) begin
      instr_word <= w2;
      repeat (4) @(posedge clk_sys);
    end
    instr_valid <= 1'b0;
    wait_rdy();
    @(negedge clk_sys);
  endtask
  task automatic reg_io(input bit rd, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= rd;
    reg_wr <= !rd;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    @(negedge clk_sys);
    if (rd) chk(reg_rdata, d);
  endtask
  // Stores over both banks, index mode edge at 95
  task automatic t_store();
    logic [15:0] wd [6] = '{16'h6fff, 16'h6f00, 16'h6e10, 16'h6ea0, 16'h6e5f, 16'h6e60};
    logic [11:0] ad [6] = '{12'h3ff, 12'h300, 12'h010, 12'hfa0, 12'h25f, 12'hf60};
    reg_io(0, `MRR_OFF_BANK, 32'hf3);
    reg_io(1, `MRR_OFF_BANK, 32'h3);
    reg_io(1, 8'h40, 32'h0);
    for (int i = 0; i < 6; i++) begin
      if (i == 4) reg_io(0, `MRR_OFF_CTRL, 32'h1);
      run(16'h0e40 + 16'(i), 0, 0);
      run(wd[i], 0, 0);
      chk(far.mem[ad[i]], 8'h40 + 8'(i));
    end
  endtask
  // Returns of every kind, with and without shadows
  task automatic t_ret();
    logic [15:0] op [5] = '{16'h0012, 16'h0013, 16'h0011, 16'h0010, 16'h0c77};
    logic [7:0] ef, eb;
    ef = 8'h00;
    eb = 8'h03;
    for (int i = 0; i < 5; i++) begin
      run(16'h0e99, 0, 0);
      run(op[i], 0, 0);
      if (i == 1 || i == 2) ef = flags_shadow;
      if (i == 1 || i == 2) eb = bank_select_shadow;
      chk(pc_value, 21'(7 - i) << 8);
      chk(working_reg, i == 4 ? 8'h77 : i == 1 || i == 2 ? working_shadow : 8'h99);
      chk(flags_reg, ef);
      chk(bank_select_reg, eb);
      chk({gh, gl}, i < 2 ? 2'b00 : i == 2 ? 2'b10 : 2'b11);
    end
  endtask
  // Rotate through carry, result to W or back to memory
  task automatic t_rot();
    logic [7:0] v [4] = '{8'he6, 8'h00, 8'h80, 8'h7f};
    logic [7:0] r, f;
    f = flags_shadow;
    for (int i = 0; i < 4; i++) begin
      far.mem[12'h520] = v[i];
      r = {v[i][6:0], f[`MRR_FLAG_C]};
      f[`MRR_FLAG_C] = v[i][7];
      f[`MRR_FLAG_Z] = r == 8'h00;
      f[`MRR_FLAG_N] = r[7];
      run({6'h0d, i[0], 9'h120}, 0, 0);
      chk(i[0] ? far.mem[12'h520] : working_reg, r);
      chk(flags_reg, f);
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    run(16'h0e80, 0, 0);
    chk(working_reg, 8'h80);
    chk(flags_reg, 8'h00);
    t_store();
    far.mem[12'h123] = 8'h33;
    run(16'hc123, 16'hf456, 1);
    chk(far.mem[12'h456], 8'h33);
    t_ret();
    // Software view after the returns: both enables, extended set, PC, W, flags
    reg_io(1, `MRR_OFF_CTRL, 32'h7);
    reg_io(1, `MRR_OFF_PC, 32'h300);
    reg_io(1, `MRR_OFF_WORK, 32'h77);
    reg_io(1, `MRR_OFF_FLAGS, 32'h10);
    t_rot();
    conclude();
  end
  // Hang guard: the sequence needs under 2000 cycles
  initial begin
    #50000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
